/* File: logic/btc_cal_gen.sv */
// Purpose: Divide-by-64 calibration clock with pulse skipping per 2^20 window.
// Assumes: rtc_tick_i is a one-cycle enable marking each RTC clock pulse.
// Notes:   Skipped pulses are the first cal_i pulses of each window.
`timescale 1ns/1ps
module btc_cal_gen
  import btc_pkg::*;
(
  input  wire logic              clk_i,
  input  wire logic              rst_i,
  input  wire logic              rtc_tick_i,
  input  wire logic [CAL_W-1:0]  cal_i,
  output logic                   cal_tick_o,
  output logic                   div64_o
);

  logic [WIN_W-1:0]   win_r;
  logic [DIV64_W-1:0] div_r;
  wire                skip_w;
  wire                adv_w;

  // Skip the first cal_i pulses in every window; this slows the clock.
  assign skip_w = (win_r < WIN_W'(cal_i));
  assign adv_w  = rtc_tick_i && !skip_w;

  // Window counter wraps after 2^20 pulses naturally.
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      win_r <= '0;
    else if (rtc_tick_i)
      win_r <= win_r + 1'b1;
  end

  // The top divider bit is a 50 percent duty clock at RTC/64.
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      div_r      <= '0;
      cal_tick_o <= 1'b0;
    end
    else
    begin
      cal_tick_o <= adv_w;
      if (adv_w)
        div_r <= div_r + 1'b1;
    end
  end

  assign div64_o = div_r[DIV64_W-1];

endmodule : btc_cal_gen

/* File: logic/btc_pkg.sv */
// Purpose: Constants for the backup tamper and RTC calibration output block.
// Assumes: Classic Wishbone slave with 32-bit data, byte addressed, word aligned.
// Notes:   Registers are 16 bits wide and sit in the low half of each word.
package btc_pkg;

  // ***************************************************************
  // Widths and counts
  // ***************************************************************
  localparam int unsigned ADDR_W   = 8;
  localparam int unsigned DATA_W   = 32;
  localparam int unsigned REG_W    = 16;
  localparam int unsigned NUM_DATA = 42;
  localparam int unsigned CAL_W    = 7;
  localparam int unsigned DIV64_W  = 6;
  localparam int unsigned WIN_W    = 20;

  // ***************************************************************
  // Register offsets
  // ***************************************************************
  localparam logic [ADDR_W-1:0] OFS_DATA_LO_FIRST = 8'h04;
  localparam logic [ADDR_W-1:0] OFS_DATA_LO_LAST  = 8'h28;
  localparam logic [ADDR_W-1:0] OFS_CAL_CTRL      = 8'h2C;
  localparam logic [ADDR_W-1:0] OFS_TAMPER_CTRL   = 8'h30;
  localparam logic [ADDR_W-1:0] OFS_TAMPER_STAT   = 8'h34;
  localparam logic [ADDR_W-1:0] OFS_DATA_HI_FIRST = 8'h40;
  localparam logic [ADDR_W-1:0] OFS_DATA_HI_LAST  = 8'hBC;
  localparam int unsigned       DATA_LO_COUNT     = 10;

  // ***************************************************************
  // Field positions
  // ***************************************************************
  localparam int unsigned BIT_PULSE_SEL   = 9;
  localparam int unsigned BIT_PULSE_EN    = 8;
  localparam int unsigned BIT_CAL_CLK_OUT = 7;
  localparam int unsigned BIT_TAMPER_POL  = 1;
  localparam int unsigned BIT_TAMPER_EN   = 0;
  localparam int unsigned BIT_IRQ_FLAG    = 9;
  localparam int unsigned BIT_EVENT_FLAG  = 8;
  localparam int unsigned BIT_IRQ_EN      = 2;
  localparam int unsigned BIT_CLR_IRQ     = 1;
  localparam int unsigned BIT_CLR_EVENT   = 0;

  // ***************************************************************
  // Reset values
  // ***************************************************************
  localparam logic [REG_W-1:0] RST_DATA = 16'h0000;
  localparam logic [CAL_W-1:0] RST_CAL  = 7'h00;

endpackage : btc_pkg

/* File: logic/btc_top.sv */
// Purpose: Tamper detection, backup data words and RTC calibration/pulse output.
// Assumes: All inputs synchronous to clk_i except the tamper pin, which is synchronised.
// Notes:   Backup-domain reset, system reset and supply loss are separate inputs.
//
// Contract
// - Output select 1 routes second pulse to pin; cleared only by backup reset.
// - Output select 0 routes alarm pulse to pin instead.
// - Pulse enable drives selected pulse on pin; cleared only by backup reset.
// - Calibration clock bit drives RTC clock divided by 64 onto pin.
// - Calibration clock bit clears on main supply loss; others kept.
// - Seven-bit field gives pulses skipped in each 2^20 pulse window.
// - Polarity 0 means rising edge is tamper; 1 means falling edge.
// - Tamper enable 1 uses pin for tamper; 0 leaves it ordinary I/O.
// - Every tamper event clears all backup data words to zero.
// - Edges latch while detection disabled and fire once enabled.
// - Clearing polarity and enable together gives a spurious tamper event.
// - Interrupt flag sets on event with enable; clears by strobe or disable.
// - Interrupt flag and enable reset only by system reset or standby wake.
// - Event flag sets on every event, clears only by clear-event strobe; the code also clears it on backup reset.
// - While event flag is set, data words stay zero and ignore writes.
// - Interrupt enable gates the request, effective only with detection enabled.
// - Tamper interrupt never acts as a wake-up source.
// - Clear bits are write-only strobes reading as zero.
//
// Our own choice: the Wishbone register port.
`timescale 1ns/1ps
module btc_top
  import btc_pkg::*;
(
  input  wire logic                clk_i,
  input  wire logic                rst_i,
  input  wire logic                bkp_rst_i,
  input  wire logic                standby_wake_i,
  input  wire logic                vdd_off_i,
  input  wire logic                wb_cyc_i,
  input  wire logic                wb_stb_i,
  input  wire logic                wb_we_i,
  input  wire logic [ADDR_W-1:0]   wb_adr_i,
  input  wire logic [3:0]          wb_sel_i,
  input  wire logic [DATA_W-1:0]   wb_dat_i,
  output logic      [DATA_W-1:0]   wb_dat_o,
  output logic                     wb_ack_o,
  input  wire logic                tamper_pin_i,
  input  wire logic                rtc_tick_i,
  input  wire logic                second_pulse_i,
  input  wire logic                alarm_pulse_i,
  output logic                     pin_o,
  output logic                     pin_oe_o,
  output logic                     tamper_irq_o,
  output logic                     tamper_event_o
);

  import btc_pkg::*;

  // ***************************************************************
  // State
  // ***************************************************************
  logic [REG_W-1:0]  data_r [NUM_DATA];
  logic              pulse_output_select_r;
  logic              pulse_output_enable_r;
  logic              cal_clock_output_r;
  logic [CAL_W-1:0]  cal_r;
  logic              tamper_polarity_r;
  logic              tamper_enable_r;
  logic              tamper_irq_flag_r;
  logic              tamper_event_flag_r;
  logic              tamper_irq_enable_r;
  logic              sync1_r;
  logic              sync2_r;
  logic              pend_r;
  logic              level_prev_r;
  logic              div64;

  // ***************************************************************
  // Bus decode
  // ***************************************************************
  wire        req_w      = wb_cyc_i && wb_stb_i && !wb_ack_o;
  wire        wr_w       = req_w && wb_we_i;
  wire        lo_w       = wb_sel_i[0];
  wire        hi_w       = wb_sel_i[1];
  wire        hit_cal_w  = (wb_adr_i == OFS_CAL_CTRL);
  wire        hit_tpc_w  = (wb_adr_i == OFS_TAMPER_CTRL);
  wire        hit_tps_w  = (wb_adr_i == OFS_TAMPER_STAT);
  wire        in_lo_w    = (wb_adr_i >= OFS_DATA_LO_FIRST) && (wb_adr_i <= OFS_DATA_LO_LAST);
  wire        in_hi_w    = (wb_adr_i >= OFS_DATA_HI_FIRST) && (wb_adr_i <= OFS_DATA_HI_LAST);
  wire        aligned_w  = (wb_adr_i[1:0] == 2'b00);
  wire [5:0]  word_w     = wb_adr_i[7:2];
  wire [5:0]  idx_lo_w   = 6'(word_w - 6'h01);
  wire [5:0]  idx_hi_w   = 6'(word_w - 6'h10 + 6'(DATA_LO_COUNT));
  wire        data_hit_w = aligned_w && (in_lo_w || in_hi_w);
  wire [5:0]  idx_w      = in_lo_w ? idx_lo_w : idx_hi_w;
  wire [REG_W-1:0] wdat_w = wb_dat_i[REG_W-1:0];

  // ***************************************************************
  // Tamper detection
  // ***************************************************************
  // Only the second flop is looked at, to keep metastability away.
  always_ff @(posedge clk_i)
  begin
    sync1_r <= tamper_pin_i;
    sync2_r <= sync1_r;
  end

  // The active level folds polarity in, so one edge detector serves both senses.
  wire level_w = sync2_r ^ tamper_polarity_r;
  wire edge_w  = level_w && !level_prev_r;
  // Write to control register this cycle, decoded for polarity and enable.
  wire tpc_wr_w   = wr_w && hit_tpc_w && lo_w;
  wire both_clr_w = tpc_wr_w && tamper_polarity_r && tamper_enable_r
                    && !wdat_w[BIT_TAMPER_POL] && !wdat_w[BIT_TAMPER_EN];
  // Pending memory fires as soon as detection is on.
  wire event_w = (tamper_enable_r && (pend_r || edge_w)) || both_clr_w;

  // Edges are remembered only while detection is disabled and consumed by an event.
  always_ff @(posedge clk_i)
  begin
    if (bkp_rst_i)
    begin
      level_prev_r <= 1'b0;
      pend_r       <= 1'b0;
    end
    else
    begin
      level_prev_r <= level_w;
      if (edge_w && !tamper_enable_r)
        pend_r <= 1'b1;
      else if (event_w)
        pend_r <= 1'b0;
    end
  end

  // ***************************************************************
  // Status flags
  // ***************************************************************
  wire tps_wr_w = wr_w && hit_tps_w && lo_w;
  wire clr_ev_w = tps_wr_w && wdat_w[BIT_CLR_EVENT];
  wire clr_iq_w = tps_wr_w && wdat_w[BIT_CLR_IRQ];
  wire ie_nxt   = tps_wr_w ? wdat_w[BIT_IRQ_EN] : tamper_irq_enable_r;

  // Event flag sits in the backup domain; a new event beats a clear.
  always_ff @(posedge clk_i)
  begin
    if (bkp_rst_i)
      tamper_event_flag_r <= 1'b0;
    else if (event_w)
      tamper_event_flag_r <= 1'b1;
    else if (clr_ev_w)
      tamper_event_flag_r <= 1'b0;
  end

  // Interrupt state resets only with the system or a standby wake.
  always_ff @(posedge clk_i)
  begin
    if (rst_i || standby_wake_i)
    begin
      tamper_irq_enable_r <= 1'b0;
      tamper_irq_flag_r   <= 1'b0;
    end
    else
    begin
      tamper_irq_enable_r <= ie_nxt;
      if (!ie_nxt)
        tamper_irq_flag_r <= 1'b0;
      else if (event_w && tamper_irq_enable_r)
        tamper_irq_flag_r <= 1'b1;
      else if (clr_iq_w)
        tamper_irq_flag_r <= 1'b0;
    end
  end

  // Level request only; it has no path into any wake-up logic.
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      tamper_irq_o   <= 1'b0;
      tamper_event_o <= 1'b0;
    end
    else
    begin
      tamper_irq_o   <= tamper_irq_flag_r && tamper_irq_enable_r && tamper_enable_r;
      tamper_event_o <= tamper_event_flag_r;
    end
  end

  // ***************************************************************
  // Control registers
  // ***************************************************************
  wire cal_wr_w = wr_w && hit_cal_w;

  // Backup-domain controls; the clock output bit also drops on supply loss.
  always_ff @(posedge clk_i)
  begin
    if (bkp_rst_i)
    begin
      pulse_output_select_r <= 1'b0;
      pulse_output_enable_r <= 1'b0;
      cal_clock_output_r    <= 1'b0;
      cal_r                 <= RST_CAL;
      tamper_polarity_r     <= 1'b0;
      tamper_enable_r       <= 1'b0;
    end
    else
    begin
      if (vdd_off_i)
        cal_clock_output_r <= 1'b0;
      else if (cal_wr_w && lo_w)
        cal_clock_output_r <= wdat_w[BIT_CAL_CLK_OUT];
      if (cal_wr_w && lo_w)
        cal_r <= wdat_w[CAL_W-1:0];
      if (cal_wr_w && hi_w)
      begin
        pulse_output_select_r <= wdat_w[BIT_PULSE_SEL];
        pulse_output_enable_r <= wdat_w[BIT_PULSE_EN];
      end
      if (tpc_wr_w)
      begin
        tamper_polarity_r <= wdat_w[BIT_TAMPER_POL];
        tamper_enable_r   <= wdat_w[BIT_TAMPER_EN];
      end
    end
  end

  // ***************************************************************
  // Backup data words
  // ***************************************************************
  // Each word clears on an event and stays locked while the event flag stands.
  genvar gi;
  generate
    for (gi = 0; gi < NUM_DATA; gi++)
    begin : g_data
      wire sel_w = wr_w && data_hit_w && (idx_w == 6'(gi));
      always_ff @(posedge clk_i)
      begin
        if (bkp_rst_i || event_w || tamper_event_flag_r)
          data_r[gi] <= RST_DATA;
        else if (sel_w)
        begin
          if (lo_w)
            data_r[gi][7:0] <= wdat_w[7:0];
          if (hi_w)
            data_r[gi][15:8] <= wdat_w[15:8];
        end
      end
    end
  endgenerate

  // ***************************************************************
  // Read mux and acknowledge
  // ***************************************************************
  logic [REG_W-1:0] rd_w;
  always_comb
  begin
    rd_w = '0;
    if (data_hit_w)
      rd_w = data_r[idx_w];
    else if (hit_cal_w)
      rd_w = {6'h00, pulse_output_select_r, pulse_output_enable_r, cal_clock_output_r, cal_r};
    else if (hit_tpc_w)
      rd_w = {14'h0000, tamper_polarity_r, tamper_enable_r};
    else if (hit_tps_w)
      rd_w = {6'h00, tamper_irq_flag_r, tamper_event_flag_r, 5'h00, tamper_irq_enable_r, 2'b00};
  end

  // One wait-free answer per request; unmapped addresses read zero.
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= '0;
    end
    else
    begin
      wb_ack_o <= req_w;
      wb_dat_o <= req_w ? {16'h0000, rd_w} : '0;
    end
  end

  // ***************************************************************
  // Pin output
  // ***************************************************************
  btc_cal_gen u_cal
  (
    .clk_i      (clk_i),
    .rst_i      (bkp_rst_i),
    .rtc_tick_i (rtc_tick_i),
    .cal_i      (cal_r),
    .cal_tick_o (),
    .div64_o    (div64)
  );

  // Tamper mode owns the pin as input; the calibration clock wins over pulses.
  wire pulse_w = pulse_output_select_r ? second_pulse_i : alarm_pulse_i;
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      pin_o    <= 1'b0;
      pin_oe_o <= 1'b0;
    end
    else
    begin
      pin_oe_o <= !tamper_enable_r && (cal_clock_output_r || pulse_output_enable_r);
      pin_o    <= cal_clock_output_r ? div64 : (pulse_output_enable_r && pulse_w);
    end
  end

endmodule : btc_top

/* File: testbench/btc_asserts.sv */
// Purpose: Port-level checks for the backup tamper and calibration output block.
// Assumes: Classic Wishbone master with one request outstanding.
// Notes:   Checks rest while system reset is high.
`timescale 1ns/1ps
module btc_asserts
  import btc_pkg::*;
(
  input  wire logic              clk_i,
  input  wire logic              rst_i,
  input  wire logic              bkp_rst_i,
  input  wire logic              wb_cyc_i,
  input  wire logic              wb_stb_i,
  input  wire logic              wb_we_i,
  input  wire logic [ADDR_W-1:0] wb_adr_i,
  input  wire logic [3:0]        wb_sel_i,
  input  wire logic [DATA_W-1:0] wb_dat_i,
  input  wire logic [DATA_W-1:0] wb_dat_o,
  input  wire logic              wb_ack_o,
  input  wire logic              pin_oe_o,
  input  wire logic              tamper_irq_o,
  input  wire logic              tamper_event_o
);
  // Decode of a taken request and of the data word window.
  wire req_w = wb_cyc_i && wb_stb_i && !wb_ack_o;
  wire wr_w  = req_w && wb_we_i && wb_sel_i[0];
  wire stat_w = wr_w && wb_adr_i == OFS_TAMPER_STAT;
  wire clr_w  = stat_w && wb_dat_i[BIT_CLR_EVENT];
  wire lo_w = wb_adr_i >= OFS_DATA_LO_FIRST && wb_adr_i <= OFS_DATA_LO_LAST;
  wire hi_w = wb_adr_i >= OFS_DATA_HI_FIRST && wb_adr_i <= OFS_DATA_HI_LAST;
  wire dat_w = wb_adr_i[1:0] == 2'h0 && (lo_w || hi_w);

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  // Writes whose effect reaches the pins two edges later.
  sequence s_irq_off;
    stat_w && !wb_dat_i[BIT_IRQ_EN];
  endsequence
  sequence s_tamper_on;
    wr_w && wb_adr_i == OFS_TAMPER_CTRL && wb_dat_i[BIT_TAMPER_EN];
  endsequence
  sequence s_out_off;
    wr_w && wb_sel_i[1] && wb_adr_i == OFS_CAL_CTRL && wb_dat_i[9:7] == 3'h0;
  endsequence

  a_ack_follows_req:
    assert property (req_w |=> wb_ack_o) else $error("request not acknowledged");
  a_ack_one_cycle:
    assert property (wb_ack_o |=> !wb_ack_o) else $error("ack longer than one cycle");
  a_ack_has_cause:
    assert property (wb_ack_o |-> $past(req_w)) else $error("ack without request");
  a_read_upper_zero:
    assert property (wb_ack_o |-> wb_dat_o[31:16] == 16'h0000) else $error("upper half not zero");
  a_event_holds:
    assert property (tamper_event_o && !clr_w && !$past(clr_w) && !bkp_rst_i && !$past(bkp_rst_i)
      |=> tamper_event_o) else $error("event flag dropped by itself");
  a_irq_off_drops:
    assert property (s_irq_off |-> ##2 !tamper_irq_o) else $error("irq kept after disable");
  a_tamper_mutes_pin:
    assert property (s_tamper_on |-> ##2 !pin_oe_o) else $error("pin driven in tamper mode");
  a_outputs_off_quiet:
    assert property (s_out_off |-> ##2 !pin_oe_o) else $error("pin driven with outputs off");
  a_data_zero_event:
    assert property (wb_ack_o && !wb_we_i && dat_w && tamper_event_o |-> wb_dat_o == 32'h0)
      else $error("data word not cleared");
endmodule : btc_asserts

bind btc_top btc_asserts btc_asserts_inst (.clk_i, .rst_i, .bkp_rst_i, .wb_cyc_i, .wb_stb_i,
  .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .pin_oe_o, .tamper_irq_o,
  .tamper_event_o);

/* File: testbench/btc_pin_model.sv */
// Purpose: Tamper switch, pulse sources and RTC tick source outside the block.
// Assumes: Levels are commanded by the bench; ticks come every TICK_GAP cycles.
// Notes:   A larger TICK_GAP gives a slow clock; ticks stop when not running.
`timescale 1ns/1ps
module btc_pin_model #(
  parameter int unsigned TICK_GAP = 8
) (
  input  wire logic  clk_i,
  input  wire logic  tamper_lvl_i,
  input  wire logic  tick_run_i,
  input  wire logic  second_lvl_i,
  input  wire logic  alarm_lvl_i,
  output logic       tamper_pin_o,
  output logic       rtc_tick_o,
  output logic       second_pulse_o,
  output logic       alarm_pulse_o,
  output int         tick_count_o
);
  int gap = 0;

  initial
  begin
    tamper_pin_o = 1'b0;
    rtc_tick_o = 1'b0;
    second_pulse_o = 1'b0;
    alarm_pulse_o = 1'b0;
    tick_count_o = 0;
  end

  // The switch and sources follow their commands one edge late, as real wiring lags software.
  always @(posedge clk_i)
  begin
    tamper_pin_o <= tamper_lvl_i;
    second_pulse_o <= second_lvl_i;
    alarm_pulse_o <= alarm_lvl_i;
    rtc_tick_o <= tick_run_i && gap == 0;
    if (tick_run_i && gap == 0)
      tick_count_o <= tick_count_o + 1;
    gap <= (!tick_run_i || gap == TICK_GAP - 1) ? 0 : gap + 1;
  end
endmodule : btc_pin_model

/* File: testbench/tb.sv */
// Purpose: Register-level bench for the tamper and calibration output block.
// Assumes: Wishbone reads and writes are 16-bit values on lanes 0 and 1.
// Notes:   Calibration skip is seen from the first ticks after backup reset.
`timescale 1ns/1ps
module tb;
  import btc_pkg::*;
  logic              clk_i = 1'b0;
  logic [3:0]        ctl = 4'h9;
  logic              rst_i, standby_wake_i, vdd_off_i, bkp_rst_i;
  logic              wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0;
  logic [ADDR_W-1:0] wb_adr_i = 8'h00;
  logic [3:0]        wb_sel_i = 4'h3;
  logic [DATA_W-1:0] wb_dat_i = 32'h0, wb_dat_o;
  logic              wb_ack_o, pin_o, pin_oe_o, tamper_irq_o, tamper_event_o;
  logic              tamper_pin_i, rtc_tick_i, second_pulse_i, alarm_pulse_i;
  logic              sw = 1'b0, run = 1'b0, sec = 1'b0, alm = 1'b0;
  int                ticks, bad_count = 0, check_count = 0, cyc_n = 0;
  localparam logic [15:0] CALV = 16'h0005;

  assign {bkp_rst_i, vdd_off_i, standby_wake_i, rst_i} = ctl;
  always #2.5 clk_i = ~clk_i;

  btc_top btc_top_inst (.clk_i, .rst_i, .bkp_rst_i, .standby_wake_i, .vdd_off_i, .wb_cyc_i,
    .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .tamper_pin_i,
    .rtc_tick_i, .second_pulse_i, .alarm_pulse_i, .pin_o, .pin_oe_o, .tamper_irq_o, .tamper_event_o);
  btc_pin_model btc_pin_model_inst (.clk_i, .tamper_lvl_i(sw), .tick_run_i(run), .second_lvl_i(sec),
    .alarm_lvl_i(alm), .tamper_pin_o(tamper_pin_i), .rtc_tick_o(rtc_tick_i),
    .second_pulse_o(second_pulse_i), .alarm_pulse_o(alarm_pulse_i), .tick_count_o(ticks));

  task automatic give_verdict();
    $display("checks %0d mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : give_verdict

  // A hung handshake must not stall the run forever.
  always @(posedge clk_i)
  begin
    cyc_n++;
    if (cyc_n == 6000)
    begin
      bad_count++;
      give_verdict();
    end
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp)
      $display("wrong value at %0t got %h expected %h", $time, got, exp);
    if (got !== exp)
      bad_count++;
  endtask : chk

  // One classic cycle: hold everything until ack is sampled, then release.
  task automatic wb(input logic we, input logic [7:0] a, input logic [15:0] d, output logic [31:0] q);
    @(posedge clk_i);
    {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_dat_i} <= {2'h3, we, a, 16'h0000, d};
    do @(posedge clk_i); while (wb_ack_o !== 1'b1);
    q = wb_dat_o;
    {wb_cyc_i, wb_stb_i, wb_we_i} <= 3'h0;
  endtask : wb

  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    logic [31:0] q;
    wb(1'b1, a, d, q);
  endtask : wr

  task automatic rc(input logic [7:0] a, input logic [15:0] e);
    logic [31:0] q;
    wb(1'b0, a, 16'h0000, q);
    chk(q, {16'h0000, e});
  endtask : rc

  task automatic evt(input logic e);
    for (int n = 0; n < 40 && tamper_event_o !== e; n++)
      @(posedge clk_i);
    chk({31'h0, tamper_event_o}, {31'h0, e});
  endtask : evt

  task automatic hit(input logic [3:0] m);
    @(posedge clk_i);
    ctl <= m;
    @(posedge clk_i);
    ctl <= 4'h0;
  endtask : hit

  task automatic pin_at(input int exp_ticks);
    logic p;
    p = pin_o;
    for (int n = 0; n < 2000 && pin_o === p; n++)
      @(posedge clk_i);
    chk(ticks, exp_ticks);
  endtask : pin_at

  task automatic pin_is(input logic oe, input logic v);
    repeat (3) @(posedge clk_i);
    chk({pin_oe_o, pin_o}, {oe, v});
  endtask : pin_is

  // Main sequence: registers, tamper paths, pin outputs, then the reset domains.
  initial
  begin
    repeat (12) @(posedge clk_i);
    ctl <= 4'h0;
    rc(OFS_CAL_CTRL, 16'h0000);
    rc(OFS_TAMPER_CTRL, 16'h0000);
    rc(OFS_TAMPER_STAT, 16'h0000);
    wr(8'h38, 16'hFFFF);
    rc(8'h38, 16'h0000);
    wr(8'h04, 16'hA5C3);
    wr(8'hBC, 16'h5A3C);
    rc(8'h04, 16'hA5C3);
    rc(8'hBC, 16'h5A3C);
    wr(OFS_TAMPER_STAT, 16'h0007);
    rc(OFS_TAMPER_STAT, 16'h0004);
    wr(OFS_TAMPER_CTRL, 16'h0001);
    sw <= 1'b1;
    evt(1'b1);
    chk({31'h0, tamper_irq_o}, 32'h1);
    rc(OFS_TAMPER_STAT, 16'h0304);
    rc(8'hBC, 16'h0000);
    wr(8'h04, 16'h1111);
    rc(8'h04, 16'h0000);
    wr(OFS_TAMPER_STAT, 16'h0006);
    rc(OFS_TAMPER_STAT, 16'h0104);
    wr(OFS_TAMPER_STAT, 16'h0005);
    evt(1'b0);
    wr(8'h04, 16'h2222);
    rc(8'h04, 16'h2222);
    wr(OFS_TAMPER_CTRL, 16'h0000);
    wr(OFS_TAMPER_CTRL, 16'h0002);
    sw <= 1'b0;
    repeat (10) @(posedge clk_i);
    chk({31'h0, tamper_event_o}, 32'h0);
    wr(OFS_TAMPER_CTRL, 16'h0003);
    evt(1'b1);
    wr(OFS_TAMPER_STAT, 16'h0000);
    rc(OFS_TAMPER_STAT, 16'h0100);
    sw <= 1'b1;
    wr(OFS_TAMPER_STAT, 16'h0001);
    evt(1'b0);
    wr(OFS_TAMPER_CTRL, 16'h0000);
    evt(1'b1);
    wr(OFS_TAMPER_STAT, 16'h0001);
    evt(1'b0);
    sec <= 1'b1;
    wr(OFS_CAL_CTRL, 16'h0300);
    pin_is(1'b1, 1'b1);
    wr(OFS_CAL_CTRL, 16'h0100);
    pin_is(1'b1, 1'b0);
    alm <= 1'b1;
    pin_is(1'b1, 1'b1);
    wr(OFS_CAL_CTRL, 16'h0000);
    pin_is(1'b0, 1'b0);
    wr(OFS_CAL_CTRL, 16'h0080 | CALV);
    run <= 1'b1;
    pin_at(CALV + 32);
    pin_at(CALV + 64);
    run <= 1'b0;
    wr(OFS_CAL_CTRL, 16'h0380 | CALV);
    hit(4'h4);
    rc(OFS_CAL_CTRL, 16'h0300 | CALV);
    wr(OFS_TAMPER_STAT, 16'h0004);
    wr(8'h40, 16'h1234);
    hit(4'h1);
    rc(OFS_TAMPER_STAT, 16'h0000);
    rc(8'h40, 16'h1234);
    rc(OFS_CAL_CTRL, 16'h0300 | CALV);
    wr(OFS_TAMPER_STAT, 16'h0004);
    hit(4'h2);
    rc(OFS_TAMPER_STAT, 16'h0000);
    hit(4'h8);
    rc(OFS_CAL_CTRL, 16'h0000);
    rc(8'h40, 16'h0000);
    give_verdict();
  end
endmodule : tb
